// >>> shared/gas_pkg.sv
// Shared constants and types for the gas sensor control logic.
package gas_pkg;
	localparam int PPM_W = 16;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int ERR_W = 8;

	// Register byte offsets on the Wishbone slave.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BG_TARGET = 8'h04;
	localparam logic [7:0] REG_PR_HI = 8'h14;
	localparam logic [7:0] REG_ERROR = 8'h18;
	localparam logic [7:0] REG_READING = 8'h1C;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_ZERO_OFFSET = 8'h24;
	localparam logic [7:0] REG_OUT_CODES = 8'h28;

	// Configuration words, indexed from REG_BG_TARGET in steps of one word.
	localparam int CFG_N = 5;
	localparam int CFG_BG = 0;
	localparam int CFG_OV_LO = 1;
	localparam int CFG_OV_HI = 2;
	localparam int CFG_PR_LO = 3;
	localparam int CFG_PR_HI = 4;
	// Reset values: 400 ppm target, 0..4000 mV overview, 1000..5000 mV precise.
	localparam logic [15:0] CFG_RST [CFG_N] = '{16'h0190, 16'h0000, 16'h0FA0, 16'h03E8, 16'h1388};

	// Control and status bit positions.
	localparam int CTRL_ABC_EN = 0;
	localparam logic CTRL_ABC_EN_RST = 1'h1;
	localparam int STAT_OK = 0;
	localparam int STAT_LOWER = 1;
	localparam int STAT_UPPER = 2;
	localparam int STAT_CAL_BG = 3;
	localparam int STAT_CAL_ZERO = 4;
	localparam int STAT_RUN = 5;

	// Error byte bit positions; the sticky mask holds every bit software must clear.
	localparam int ERR_FATAL = 0;
	localparam int ERR_OFFSET = 1;
	localparam int ERR_ALGORITHM = 2;
	localparam int ERR_OUTPUT = 3;
	localparam int ERR_SELFDIAG = 4;
	localparam int ERR_RANGE = 5;
	localparam int ERR_MEMORY = 6;
	localparam int ERR_RESERVED = 7;
	localparam logic [7:0] ERR_STICKY_MASK = 8'h5D;

	// Concentrations in ppm.
	localparam logic [15:0] FULL_SCALE_PPM = 16'h07D0;
	localparam logic [15:0] ZERO_TARGET_PPM = 16'h0000;
	localparam logic [15:0] FRESH_AIR_PPM = 16'h0190;
	localparam logic [15:0] ABC_STEP_PPM = 16'h001E;
	localparam logic [15:0] LOWER_OFF_PPM = 16'h02BC;
	localparam logic [15:0] LOWER_ON_PPM = 16'h0320;
	localparam logic [15:0] UPPER_OFF_PPM = 16'h0384;
	localparam logic [15:0] UPPER_ON_PPM = 16'h03E8;
	localparam logic [15:0] RAW_MAX_DEF = 16'h3FFF;
	localparam logic [15:0] OFFSET_LIMIT_DEF = 16'h0400;

	// Timing: a one-second tick drives every slow count.
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int QUAL_TIME_S = 8;
	localparam int SELFTEST_TIME_S = 2;
	localparam int SECONDS_PER_HALF_DAY = 43200;
	localparam int ABC_PERIOD_HALF_DAYS = 15;
	localparam int ABC_PERIOD_S_DEF = ABC_PERIOD_HALF_DAYS * SECONDS_PER_HALF_DAY;

	typedef enum logic [1:0] {MODE_SELFTEST = 2'b00, MODE_RUN = 2'b01} mode_type;
	typedef enum logic [1:0] {NV_IDLE = 2'b00, NV_VERIFY = 2'b01} nvm_type;
endpackage

// >>> shared/level_if.sv
// Concentration and threshold pair carried to a level alarm.
`timescale 1ns/100ps
`default_nettype none
interface level_if;
	logic [15:0] ppm;
	logic [15:0] thr_on;
	logic [15:0] thr_off;
	modport src(output ppm, output thr_on, output thr_off);
	modport sink(input ppm, input thr_on, input thr_off);
endinterface
`default_nettype wire

// >>> hw/switch_qualify.sv
// Qualifies a grounded calibration switch after a persistent closure.
`timescale 1ns/100ps
`default_nettype none
module switch_qualify #(
	parameter int QUAL_TICKS = 8
)(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_tick,
	input wire logic i_closed,
	output logic o_qualified
);
	// One extra tick because the first tick may fall just after the closure.
	localparam int CNT_W = $clog2(QUAL_TICKS + 2);
	localparam logic [CNT_W-1:0] CNT_DONE = CNT_W'(QUAL_TICKS + 1);

	logic [CNT_W-1:0] cnt;
	wire done = (cnt == CNT_DONE);

	// The count restarts on any release so a bounce never qualifies.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt <= '0;
			o_qualified <= 1'b0;
		end
		else if (i_ce)
		begin
			if (!i_closed)
				cnt <= '0;
			else if (i_tick && !done)
				cnt <= cnt + 1'b1;
			o_qualified <= i_closed && done;
		end
	end
endmodule
`default_nettype wire

// >>> hw/level_alarm.sv
// Hysteresis alarm driven by a concentration and a threshold pair.
`timescale 1ns/100ps
`default_nettype none
module level_alarm (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	level_if.sink lv,
	output logic o_alarm
);
	// Between the two thresholds the output holds, which stops chatter.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_alarm <= 1'b0;
		else if (i_ce)
		begin
			if (lv.ppm >= lv.thr_on)
				o_alarm <= 1'b1;
			else if (lv.ppm <= lv.thr_off)
				o_alarm <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> hw/gas_sensor_control_logic.sv
// Control logic of a CO2 sensing module: scaling, alarms, calibration, baseline, errors.
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module gas_sensor_control_logic #(
	parameter int TICK_CYCLES = gas_pkg::TICK_CYCLES_DEF,
	parameter int ABC_PERIOD_TICKS = gas_pkg::ABC_PERIOD_S_DEF,
	parameter logic [15:0] RAW_MAX = gas_pkg::RAW_MAX_DEF,
	parameter logic [15:0] OFFSET_LIMIT = gas_pkg::OFFSET_LIMIT_DEF
)(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [gas_pkg::ADR_W-1:0] i_wb_adr,
	input wire logic [gas_pkg::DAT_W-1:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [gas_pkg::DAT_W-1:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic [gas_pkg::PPM_W-1:0] i_raw_ppm,
	input wire logic i_sample_valid,
	input wire logic i_probe_ok,
	input wire logic i_fatal_event,
	input wire logic i_algorithm_event,
	input wire logic i_background_cal_switch_n,
	input wire logic i_zero_cal_switch_n,
	output logic o_nvm_wr,
	output logic [15:0] o_nvm_wdata,
	input wire logic i_nvm_rvalid,
	input wire logic [15:0] i_nvm_rdata,
	output logic [15:0] o_overview_analog_out,
	output logic [15:0] o_precise_analog_out,
	output logic o_lower_level_alarm_out,
	output logic o_upper_level_alarm_out,
	output logic o_status,
	output logic [gas_pkg::ERR_W-1:0] o_error_code
);
	import gas_pkg::*;

	// Refuse settings that the counters cannot serve.
	if (TICK_CYCLES < 2 || ABC_PERIOD_TICKS < 2)
	begin : g_bad_timing
		$error("tick and baseline period must each be at least two");
	end

	localparam int PRE_W = $clog2(TICK_CYCLES);
	localparam int ABC_W = $clog2(ABC_PERIOD_TICKS);
	localparam int ST_W = $clog2(SELFTEST_TIME_S + 1);

	// Byte-lane merge of a 16-bit register with write data.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
	endfunction

	// Saturate a wide signed value into a 16-bit signed zero constant.
	function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
		if (v > 18'sh07FFF)
			sat16 = 16'sh7FFF;
		else if (v < -18'sh08000)
			sat16 = -16'sh8000;
		else
			sat16 = v[15:0];
	endfunction

	// Linear map of a concentration onto an output code between lo and hi.
	function automatic logic [15:0] scale(input logic [15:0] ppm, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [15:0] p;
		logic [31:0] prod;
		p = (ppm > FULL_SCALE_PPM) ? FULL_SCALE_PPM : ppm;
		prod = 32'(p) * 32'(hi - lo);
		scale = (hi < lo) ? lo : lo + 16'(prod / 32'(FULL_SCALE_PPM));
	endfunction

	mode_type mode;
	nvm_type nv_state;
	logic [PRE_W-1:0] pre_cnt;
	logic tick;
	logic [ST_W-1:0] st_cnt;
	logic [ABC_W-1:0] abc_cnt;
	logic [15:0] abc_min;
	logic abc_seen;
	logic abc_en;
	logic [15:0] cfg [CFG_N];
	logic signed [15:0] zero_ofs;
	logic [15:0] reading;
	logic [7:0] sticky;
	logic range_err;
	logic ofs_err;
	logic [31:0] rd_word;
	logic [1:0] qual;
	level_if lower_lv();
	level_if upper_lv();

	// One-second time base for switch timing, self-test and the baseline period.
	wire pre_last = (pre_cnt == PRE_W'(TICK_CYCLES - 1));
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pre_cnt <= '0;
			tick <= 1'b0;
		end
		else if (i_ce)
		begin
			pre_cnt <= pre_last ? '0 : pre_cnt + 1'b1;
			tick <= pre_last;
		end
	end

	// Index 0 is the background switch, index 1 the zero switch; both close to ground.
	wire [1:0] sw_closed = {~i_zero_cal_switch_n, ~i_background_cal_switch_n};
	for (genvar gi = 0; gi < 2; gi++)
	begin : g_sw
		switch_qualify #(
			.QUAL_TICKS(QUAL_TIME_S)
		) u_qual (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_ce(i_ce),
			.i_tick(tick),
			.i_closed(sw_closed[gi]),
			.o_qualified(qual[gi])
		);
	end

	// Wishbone decode; a request is taken once, in the cycle before ack rises.
	wire run = (mode == MODE_RUN);
	wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire wr_req = wb_req && i_wb_we;
	wire [7:0] cfg_off = i_wb_adr - REG_BG_TARGET;
	wire cfg_hit = (i_wb_adr >= REG_BG_TARGET) && (i_wb_adr <= REG_PR_HI)
		&& (i_wb_adr[1:0] == 2'h0);
	wire [2:0] cfg_idx = cfg_off[4:2];
	wire ctrl_wr = wr_req && (i_wb_adr == REG_CTRL) && i_wb_sel[0];
	wire err_wr = wr_req && (i_wb_adr == REG_ERROR) && i_wb_sel[0];
	wire ofs_bus_wr = wr_req && (i_wb_adr == REG_ZERO_OFFSET);

	// Calibration: the background switch wins if both are qualified at once.
	wire cal_bg = run && qual[0];
	wire cal_zero = run && qual[1] && !qual[0];
	wire [15:0] cal_target = qual[0] ? cfg[CFG_BG] : ZERO_TARGET_PPM;
	wire cal_wr = (cal_bg || cal_zero) && i_sample_valid;
	wire signed [15:0] cal_ofs = sat16($signed({2'h0, i_raw_ppm})
		- $signed({2'h0, cal_target}));

	// Baseline correction: drift of the period minimum, clamped to one step.
	wire abc_last = tick && (abc_cnt == ABC_W'(ABC_PERIOD_TICKS - 1));
	wire signed [17:0] drift = $signed({2'h0, abc_min}) - $signed({2'h0, FRESH_AIR_PPM});
	wire signed [17:0] step_hi = $signed({2'h0, ABC_STEP_PPM});
	wire signed [17:0] step = (drift > step_hi) ? step_hi
		: (drift < -step_hi) ? -step_hi : drift;
	wire abc_wr = run && abc_last && abc_en && abc_seen;
	wire signed [15:0] abc_ofs = sat16($signed({{2{zero_ofs[15]}}, zero_ofs}) + step);

	// A bus store beats a calibration, which beats a baseline step.
	wire ofs_wr = ofs_bus_wr || cal_wr || abc_wr;
	wire signed [15:0] next_zero_ofs = ofs_bus_wr ? merge16(zero_ofs, i_wb_dat, i_wb_sel)
		: cal_wr ? cal_ofs : abc_ofs;

	// Corrected reading, clamped to the unsigned concentration range.
	wire signed [17:0] corr = $signed({2'h0, i_raw_ppm}) - $signed({{2{zero_ofs[15]}}, zero_ofs});
	wire [15:0] next_reading = (corr < 18'sh0) ? 16'h0000
		: (corr > 18'sh0FFFF) ? 16'hFFFF : corr[15:0];

	// Checks feeding the error byte.
	wire [15:0] ofs_mag = zero_ofs[15] ? 16'(-zero_ofs) : zero_ofs;
	wire cfg_bad = (cfg[CFG_OV_HI] < cfg[CFG_OV_LO]) || (cfg[CFG_PR_HI] < cfg[CFG_PR_LO]);
	wire st_done = (mode == MODE_SELFTEST) && tick && (st_cnt == ST_W'(SELFTEST_TIME_S - 1));
	wire nv_bad = (nv_state == NV_VERIFY) && i_nvm_rvalid && (i_nvm_rdata != o_nvm_wdata);

	// Events that set the sticky error bits; the self-adjusting bits are not here.
	wire [7:0] err_set;
	assign err_set[ERR_FATAL] = i_fatal_event;
	assign err_set[ERR_OFFSET] = 1'b0;
	assign err_set[ERR_ALGORITHM] = i_algorithm_event;
	assign err_set[ERR_OUTPUT] = cfg_bad && (run || st_done);
	assign err_set[ERR_SELFDIAG] = st_done && !i_probe_ok;
	assign err_set[ERR_RANGE] = 1'b0;
	assign err_set[ERR_MEMORY] = nv_bad;
	assign err_set[ERR_RESERVED] = 1'b0;

	// Every present error shows at once in one byte.
	wire [7:0] auto_bits;
	assign auto_bits[ERR_OFFSET] = ofs_err;
	assign auto_bits[ERR_RANGE] = range_err;
	assign auto_bits[ERR_FATAL] = 1'b0;
	assign auto_bits[ERR_ALGORITHM] = 1'b0;
	assign auto_bits[ERR_OUTPUT] = 1'b0;
	assign auto_bits[ERR_SELFDIAG] = 1'b0;
	assign auto_bits[ERR_MEMORY] = 1'b0;
	assign auto_bits[ERR_RESERVED] = 1'b0;
	wire [7:0] err_code = (sticky & ERR_STICKY_MASK) | auto_bits;

	// Alarm thresholds travel with the reading to each hysteresis stage.
	assign lower_lv.ppm = reading;
	assign lower_lv.thr_on = LOWER_ON_PPM;
	assign lower_lv.thr_off = LOWER_OFF_PPM;
	assign upper_lv.ppm = reading;
	assign upper_lv.thr_on = UPPER_ON_PPM;
	assign upper_lv.thr_off = UPPER_OFF_PPM;

	level_alarm u_lower (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.lv(lower_lv.sink),
		.o_alarm(o_lower_level_alarm_out)
	);

	level_alarm u_upper (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.lv(upper_lv.sink),
		.o_alarm(o_upper_level_alarm_out)
	);

	// Mode sequencer: self-test first after reset, then normal running.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mode <= MODE_SELFTEST;
			st_cnt <= '0;
		end
		else if (i_ce)
		begin
			case (mode)
				MODE_SELFTEST:
				begin
					if (tick)
						st_cnt <= st_cnt + 1'b1;
					if (st_done)
						mode <= MODE_RUN;
				end
				MODE_RUN:
					mode <= MODE_RUN;
				default:
					mode <= MODE_SELFTEST;
			endcase
		end
	end

	// Configuration words stand in flip-flops indexed by address; writable at any time.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			for (int k = 0; k < CFG_N; k++)
				cfg[k] <= CFG_RST[k];
			abc_en <= CTRL_ABC_EN_RST;
		end
		else if (i_ce)
		begin
			if (wr_req && cfg_hit)
				cfg[cfg_idx] <= merge16(cfg[cfg_idx], i_wb_dat, i_wb_sel);
			if (ctrl_wr)
				abc_en <= i_wb_dat[CTRL_ABC_EN];
		end
	end

	// Zero constant and corrected reading.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			zero_ofs <= '0;
			reading <= '0;
		end
		else if (i_ce)
		begin
			if (ofs_wr)
				zero_ofs <= next_zero_ofs;
			if (i_sample_valid)
				reading <= next_reading;
		end
	end

	// Baseline period: count seconds and track the lowest reading seen.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			abc_cnt <= '0;
			abc_min <= 16'hFFFF;
			abc_seen <= 1'b0;
		end
		else if (i_ce && run)
		begin
			if (abc_last)
			begin
				abc_cnt <= '0;
				abc_min <= 16'hFFFF;
				abc_seen <= 1'b0;
			end
			else
			begin
				if (tick)
					abc_cnt <= abc_cnt + 1'b1;
				if (i_sample_valid && next_reading < abc_min)
					abc_min <= next_reading;
				abc_seen <= abc_seen || i_sample_valid;
			end
		end
	end

	// Every store of the zero constant is written out, then checked on read-back.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			nv_state <= NV_IDLE;
			o_nvm_wr <= 1'b0;
			o_nvm_wdata <= '0;
		end
		else if (i_ce)
		begin
			o_nvm_wr <= ofs_wr;
			if (ofs_wr)
			begin
				o_nvm_wdata <= next_zero_ofs;
				nv_state <= NV_VERIFY;
			end
			else
			begin
				case (nv_state)
					NV_VERIFY:
						if (i_nvm_rvalid)
							nv_state <= NV_IDLE;
					NV_IDLE:
						nv_state <= NV_IDLE;
					default:
						nv_state <= NV_IDLE;
				endcase
			end
		end
	end

	// Error byte; a set in the same cycle as a software overwrite still wins.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sticky <= '0;
			range_err <= 1'b0;
			ofs_err <= 1'b0;
		end
		else if (i_ce)
		begin
			if (err_wr)
				sticky <= (i_wb_dat[7:0] & ERR_STICKY_MASK) | err_set;
			else
				sticky <= sticky | err_set;
			if (run && i_sample_valid)
				range_err <= (i_raw_ppm > RAW_MAX) || !i_probe_ok;
			ofs_err <= ofs_mag > OFFSET_LIMIT;
		end
	end

	// Pin outputs are refreshed every cycle from the stored state.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_overview_analog_out <= CFG_RST[CFG_OV_LO];
			o_precise_analog_out <= CFG_RST[CFG_PR_LO];
			o_error_code <= '0;
			o_status <= 1'b1;
		end
		else if (i_ce)
		begin
			o_overview_analog_out <= scale(reading, cfg[CFG_OV_LO], cfg[CFG_OV_HI]);
			o_precise_analog_out <= scale(reading, cfg[CFG_PR_LO], cfg[CFG_PR_HI]);
			o_error_code <= err_code;
			o_status <= (err_code == 8'h00);
		end
	end

	// Register read selection; unmapped and unaligned addresses read as zero.
	always_comb
	begin
		rd_word = '0;
		if (cfg_hit)
			rd_word = {16'h0000, cfg[cfg_idx]};
		else
		begin
			case (i_wb_adr)
				REG_CTRL: rd_word[CTRL_ABC_EN] = abc_en;
				REG_ERROR: rd_word = {24'h00_0000, err_code};
				REG_READING: rd_word = {16'h0000, reading};
				REG_STATUS:
				begin
					rd_word[STAT_OK] = o_status;
					rd_word[STAT_LOWER] = o_lower_level_alarm_out;
					rd_word[STAT_UPPER] = o_upper_level_alarm_out;
					rd_word[STAT_CAL_BG] = cal_bg;
					rd_word[STAT_CAL_ZERO] = cal_zero;
					rd_word[STAT_RUN] = run;
				end
				REG_ZERO_OFFSET: rd_word = {{16{zero_ofs[15]}}, zero_ofs};
				REG_OUT_CODES: rd_word = {o_precise_analog_out, o_overview_analog_out};
				default: rd_word = '0;
			endcase
		end
	end

	// Wishbone answer: ack one cycle after the request, dropped the next cycle.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= '0;
		end
		else if (i_ce)
		begin
			o_wb_ack <= wb_req;
			if (wb_req && !i_wb_we)
				o_wb_dat <= rd_word;
		end
	end
endmodule
`default_nettype wire

// >>> sim/nvm_echo.sv
// Memory partner that returns every stored word, optionally corrupted.
`timescale 1ns/100ps
`default_nettype none
module nvm_echo (
	input wire logic i_clk,
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	input wire logic i_corrupt,
	output logic o_rvalid,
	output logic [15:0] o_rdata
);
	logic pend;
	initial
	begin
		pend = 1'b0;
		o_rvalid = 1'b0;
		o_rdata = 16'h0000;
	end
	// Read-back follows a store by two cycles; idle data is inverted so stale values never match.
	always @(posedge i_clk)
	begin
		pend <= i_wr;
		o_rvalid <= pend;
		o_rdata <= pend ? (i_wdata ^ {15'h0000, i_corrupt}) : ~o_rdata;
	end
endmodule
`default_nettype wire

// >>> sim/gas_sensor_control_logic_asserts.sv
// Port-level checker for the gas sensor control logic.
`timescale 1ns/100ps
`default_nettype none
module gas_sensor_control_logic_asserts #(
	parameter int TICK_CYCLES = 10
)(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [gas_pkg::ADR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [gas_pkg::DAT_W-1:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic i_sample_valid,
	input wire logic i_background_cal_switch_n,
	input wire logic i_zero_cal_switch_n,
	input wire logic o_nvm_wr,
	input wire logic o_status,
	input wire logic [gas_pkg::ERR_W-1:0] o_error_code
);
	import gas_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// A request is new while ack is low; error writes need byte lane 0.
	wire logic req = i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
	wire logic err_wr = req && i_wb_we && i_wb_sel[0] && (i_wb_adr == REG_ERROR);
	wire logic bus_store = req && i_wb_we && (i_wb_adr == REG_ZERO_OFFSET);
	wire logic any_closed = !i_background_cal_switch_n || !i_zero_cal_switch_n;
	logic [15:0] closed_cnt;
	// Cycles of unbroken closure; saturates so a long hold never wraps.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			closed_cnt <= 16'h0000;
		else if (!any_closed)
			closed_cnt <= 16'h0000;
		else if (closed_cnt != 16'hFFFF)
			closed_cnt <= closed_cnt + 16'h0001;
	end
	property p_ack;
		req |=> o_wb_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_ack_drop;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held");
	property p_unmapped;
		o_wb_ack && !i_wb_we && (i_wb_adr > REG_OUT_CODES) |-> o_wb_dat == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
	property p_status;
		$stable(o_error_code) |-> (o_status == (o_error_code == 8'h00));
	endproperty
	a_status: assert property (p_status) else $error("status wrong");
	property p_reserved;
		o_error_code[ERR_RESERVED] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");
	property p_nvm_pulse;
		o_nvm_wr |=> !o_nvm_wr;
	endproperty
	a_nvm_pulse: assert property (p_nvm_pulse) else $error("store pulse long");
	// Baseline stores come with no sample, so only calibration stores face the closure time.
	property p_qualify;
		o_nvm_wr && !$past(bus_store) && $past(i_sample_valid) && $past(any_closed) |->
			$past(closed_cnt) >= 16'(QUAL_TIME_S * TICK_CYCLES);
	endproperty
	a_qualify: assert property (p_qualify) else $error("early calibration");
	property p_sticky;
		(|($past(o_error_code) & ~o_error_code & ERR_STICKY_MASK)) |->
			($past(err_wr, 1) || $past(err_wr, 2));
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky bit cleared");
	c_store: cover property (o_nvm_wr);
	c_memory: cover property (o_error_code[ERR_MEMORY]);
	c_read: cover property (o_wb_ack && !i_wb_we);
endmodule
bind gas_sensor_control_logic gas_sensor_control_logic_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.i_clk, .i_rst_n, .i_ce, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
	.o_wb_dat, .o_wb_ack, .i_sample_valid, .i_background_cal_switch_n,
	.i_zero_cal_switch_n, .o_nvm_wr, .o_status, .o_error_code);
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the gas sensor control logic.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import gas_pkg::*;
	localparam int TK = 10;
	logic i_clk = 1'b0, i_rst_n = 1'b0, cyc = 1'b0, we = 1'b0, sv = 1'b0, ack, st, lo, up;
	logic fatal = 1'b0, algo = 1'b0, bg_n = 1'b1, zr_n = 1'b1, corrupt = 1'b0, probe = 1'b1;
	logic nvm_wr, rv;
	logic [7:0] adr = 8'h00, ec;
	logic [31:0] wdat = 32'h0000_0000, rd;
	logic [15:0] raw = 16'h0000, nvm_wd, rdat, ov, pr;
	int n_fail = 0, checked = 0;
	always #5 i_clk = ~i_clk;
	gas_sensor_control_logic #(.TICK_CYCLES(TK), .ABC_PERIOD_TICKS(20)) dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_wb_cyc(cyc), .i_wb_stb(cyc),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rd),
		.o_wb_ack(ack), .i_raw_ppm(raw), .i_sample_valid(sv), .i_probe_ok(probe),
		.i_fatal_event(fatal), .i_algorithm_event(algo), .i_background_cal_switch_n(bg_n),
		.i_zero_cal_switch_n(zr_n), .o_nvm_wr(nvm_wr), .o_nvm_wdata(nvm_wd),
		.i_nvm_rvalid(rv), .i_nvm_rdata(rdat), .o_overview_analog_out(ov),
		.o_precise_analog_out(pr), .o_lower_level_alarm_out(lo),
		.o_upper_level_alarm_out(up), .o_status(st), .o_error_code(ec));
	nvm_echo partner (.i_clk(i_clk), .i_wr(nvm_wr), .i_wdata(nvm_wd), .i_corrupt(corrupt),
		.o_rvalid(rv), .o_rdata(rdat));
	task automatic tally_and_finish();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One classic cycle; the request is held until ack is seen, then released at that edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rd;
		cyc <= 1'b0;
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask
	// One measurement pulse, then time for codes and alarms to settle.
	task automatic smp(input logic [15:0] v);
		@(posedge i_clk);
		raw <= v;
		sv <= 1'b1;
		@(posedge i_clk);
		sv <= 1'b0;
		repeat (4) @(posedge i_clk);
		#1;
	endtask
	task automatic sw(input logic b, input logic z, input int n);
		@(posedge i_clk);
		bg_n <= b;
		zr_n <= z;
		repeat (n) @(posedge i_clk);
	endtask
	// Baseline correction is switched off early so it cannot disturb the offset checks.
	initial
	begin
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rchk(REG_STATUS, 32'h0000_0001);
		rchk(REG_CTRL, 32'h0000_0001);
		rchk(REG_BG_TARGET, 32'h0000_0190);
		rchk(REG_PR_HI, 32'h0000_1388);
		rchk(8'h30, 32'h0000_0000);
		wr(REG_CTRL, 32'h0000_0000);
		repeat (4 * TK) @(posedge i_clk);
		rchk(REG_STATUS, 32'h0000_0021);
		smp(16'h03E8);
		rchk(REG_OUT_CODES, 32'h0BB8_07D0);
		chk({30'h0, lo, up}, 32'h0000_0003);
		smp(16'h02EE);
		chk({30'h0, lo, up}, 32'h0000_0002);
		smp(16'h02BC);
		chk({30'h0, lo, up}, 32'h0000_0000);
		smp(16'h0384);
		chk({30'h0, lo, up}, 32'h0000_0002);
		smp(16'h09C4);
		rchk(REG_OUT_CODES, 32'h1388_0FA0);
		wr(8'h0C, 32'h0000_07D0);
		smp(16'h03E8);
		chk({16'h0, ov}, 32'h0000_03E8);
		smp(16'h4000);
		chk({23'h0, st, ec}, 32'h0000_0020);
		smp(16'h0100);
		chk({23'h0, st, ec}, 32'h0000_0100);
		sw(1'b1, 1'b0, 5 * TK);
		smp(16'h0032);
		rchk(REG_ZERO_OFFSET, 32'h0000_0000);
		repeat (5 * TK) @(posedge i_clk);
		smp(16'h0032);
		rchk(REG_ZERO_OFFSET, 32'h0000_0032);
		smp(16'h0040);
		rchk(REG_ZERO_OFFSET, 32'h0000_0040);
		sw(1'b1, 1'b1, 1);
		smp(16'h0140);
		rchk(REG_READING, 32'h0000_0100);
		sw(1'b1, 1'b0, 6 * TK);
		sw(1'b1, 1'b1, 0);
		sw(1'b1, 1'b0, 6 * TK);
		smp(16'h0050);
		rchk(REG_ZERO_OFFSET, 32'h0000_0040);
		sw(1'b0, 1'b1, 12 * TK);
		smp(16'h01F4);
		rchk(REG_ZERO_OFFSET, 32'h0000_0064);
		wr(REG_BG_TARGET, 32'h0000_012C);
		smp(16'h01F4);
		rchk(REG_ZERO_OFFSET, 32'h0000_00C8);
		sw(1'b1, 1'b1, 2);
		corrupt <= 1'b1;
		wr(REG_ZERO_OFFSET, 32'h0000_0000);
		@(posedge i_clk);
		fatal <= 1'b1;
		algo <= 1'b1;
		@(posedge i_clk);
		fatal <= 1'b0;
		algo <= 1'b0;
		corrupt <= 1'b0;
		smp(16'h0100);
		chk({23'h0, st, ec}, 32'h0000_0045);
		wr(REG_ERROR, 32'h0000_0004);
		rchk(REG_ERROR, 32'h0000_0004);
		wr(REG_ERROR, 32'h0000_0000);
		wr(REG_ZERO_OFFSET, 32'h0000_0500);
		wr(REG_ERROR, 32'h0000_0000);
		rchk(REG_ERROR, 32'h0000_0002);
		wr(REG_ZERO_OFFSET, 32'h0000_0000);
		rchk(REG_ERROR, 32'h0000_0000);
		repeat (21 * TK) @(posedge i_clk);
		wr(REG_CTRL, 32'h0000_0001);
		smp(16'h01F4);
		repeat (21 * TK) @(posedge i_clk);
		rchk(REG_ZERO_OFFSET, 32'h0000_001E);
		// A second reset with a sick probe must end the self-test with the diagnostic bit.
		probe <= 1'b0;
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (4 * TK) @(posedge i_clk);
		#1;
		chk({23'h0, st, ec}, 32'h0000_0010);
		tally_and_finish();
	end
	// The whole sequence needs about a thousand cycles; ten thousand means a hang.
	initial
	begin
		#100000;
		n_fail++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
`default_nettype wire
